/* shared/scpm_pkg.sv */
package scpm_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_STATUS  = 8'h04;
    localparam logic [7:0] OFF_TX_MBOX = 8'h08;
    localparam logic [7:0] OFF_RX_MBOX = 8'h0C;
    localparam logic [7:0] OFF_BOOTCNT = 8'h10;

    // Control field positions
    localparam int CTRL_MASTER_EN = 0;
    localparam int CTRL_M_CLK     = 1;
    localparam int CTRL_M_DOUT    = 2;
    localparam int CTRL_M_SEL_N   = 3;
    localparam logic [3:0] CTRL_RESET = 4'h8;

    // Status field positions
    localparam int ST_MODE_LSB  = 0;
    localparam int ST_DIN       = 3;
    localparam int ST_BOOT_DONE = 4;
    localparam int ST_BUSY      = 5;
    localparam int ST_RX_FULL   = 6;

    // Slave frame layout
    localparam logic [5:0] FRM_CMD_BITS = 6'h08;
    localparam logic [5:0] FRM_LAST_BIT = 6'h27;
    localparam logic [5:0] FRM_END      = 6'h28;
    localparam logic [6:0] IDX_MBOX     = 7'h00;
    localparam int         CMD_WRITE    = 7;

    // Boot selection and length
    localparam logic [2:0]  BOOT_CFG_VALUE = 3'h1;
    localparam logic [15:0] BOOT_BYTES     = 16'h0010;
    localparam logic [1:0]  STRAP_WAIT     = 2'h2;

    // Timing
    localparam int CLK_PERIOD_NS      = 20;
    localparam int BOOT_CLK_HALF_NS   = 80;
    localparam int BOOT_HALF_CYC_INT  = (BOOT_CLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] BOOT_HALF_CYC = 8'(BOOT_HALF_CYC_INT < 1 ? 1 : BOOT_HALF_CYC_INT);

    typedef enum logic [2:0] {
        MODE_SLAVE  = 3'b001,
        MODE_MASTER = 3'b010,
        MODE_BOOT   = 3'b100
    } scpm_mode_e;

    typedef enum logic [2:0] {
        BT_IDLE = 3'b001,
        BT_RUN  = 3'b010,
        BT_DONE = 3'b100
    } scpm_boot_e;

endpackage

/* verilog/scpm_top.sv */
// Behaviour
// - The port works in exactly one of slave, master or boot role, and the role decides what each pin does.
// - In slave role an external processor writes and reads the block's mailbox registers over serial frames.
// - In master role software shapes any protocol it likes by toggling the pins through register bits.
// - When the boot configuration pins pick boot, the block clocks a boot image in from the serial memory.
// - In slave role the serial clock comes from the external master and the clock pin is only an input.
// - In slave role serial data from the external master is received on the data-in pin.
// - In slave role response data goes back to the external master on the data-out pin.
// - In slave role the external master drives select, low enables the slave and high disables it.
// - In master role clock, data-out and select are outputs that follow their software register bits.
// - In master role software reads the data-in pin level through a status bit.
// - In boot role the block drives a clock out on the clock pin to the serial memory.
// - In boot role boot data is captured from data-in and data-out is left undriven.
// - In boot role select is driven while reading the memory and released once booting is finished.
//
// Our own choices: the strobed register port and the register offsets.
module scpm_top (
    // System
    input  wire logic        clk,
    input  wire logic        nrst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Boot configuration
    input  wire logic [2:0]  cpu_boot_config_pins,
    // Boot image stream
    output logic      [7:0]  boot_byte,
    output logic             boot_byte_valid,
    output logic             boot_done,
    // Serial clock pin
    input  wire logic        port_clk_i,
    output logic             port_clk_o,
    output logic             port_clk_oe,
    // Serial data pins
    input  wire logic        port_data_in,
    output logic             port_data_out,
    output logic             port_data_out_oe,
    // Select pin
    input  wire logic        port_select_n_i,
    output logic             port_select_n_o,
    output logic             port_select_n_oe
);

    // Clock domain state
    scpm_pkg::scpm_mode_e mode_q;
    scpm_pkg::scpm_mode_e mode_d;
    scpm_pkg::scpm_boot_e bst_q;
    scpm_pkg::scpm_boot_e bst_d;
    logic [3:0]  ctrl_q;
    logic [31:0] tx_mbox_q;
    logic [31:0] rx_mbox_q;
    logic        rx_full_q;
    logic [31:0] rdata_q;
    logic [2:0]  cfg_s1_q;
    logic [2:0]  cfg_s2_q;
    logic [1:0]  strap_cnt_q;
    logic        strap_done_q;
    logic        boot_sel_q;
    logic        din_s1_q;
    logic        din_s2_q;
    logic        sel_s1_q;
    logic        sel_s2_q;
    logic        wtgl_s1_q;
    logic        wtgl_s2_q;
    logic        wtgl_s3_q;
    logic [7:0]  div_q;
    logic        bclk_q;
    logic [15:0] bbit_q;
    logic [7:0]  bshift_q;
    logic [7:0]  boot_byte_q;
    logic        boot_valid_q;
    logic        clk_o_q;
    logic        clk_oe_q;
    logic        mdo_q;
    logic        mdo_oe_q;
    logic        sel_o_q;
    logic        sel_oe_q;
    logic        slave_en_q;
    logic        boot_done_q;

    // Link domain state
    logic [5:0]  lcnt_q;
    logic [7:0]  lcmd_q;
    logic [31:0] lsh_q;
    logic [31:0] lhold_q;
    logic        wtgl_q;
    logic        so_q;
    logic        soe_q;

    // Register decode
    wire wr_ctrl  = reg_wr && (reg_addr == scpm_pkg::OFF_CTRL);
    wire wr_tx    = reg_wr && (reg_addr == scpm_pkg::OFF_TX_MBOX);
    wire rd_rx    = reg_rd && (reg_addr == scpm_pkg::OFF_RX_MBOX);
    wire slv_word = wtgl_s2_q ^ wtgl_s3_q;

    wire [31:0] status_w = {25'h000_0000, rx_full_q, ~sel_s2_q & slave_en_q, bst_q == scpm_pkg::BT_DONE,
                            din_s2_q, mode_q};

    wire [31:0] rsel_w = (reg_addr == scpm_pkg::OFF_CTRL)    ? {28'h000_0000, ctrl_q} :
                         (reg_addr == scpm_pkg::OFF_STATUS)  ? status_w :
                         (reg_addr == scpm_pkg::OFF_TX_MBOX) ? tx_mbox_q :
                         (reg_addr == scpm_pkg::OFF_RX_MBOX) ? rx_mbox_q :
                         (reg_addr == scpm_pkg::OFF_BOOTCNT) ? {16'h0000, bbit_q} :
                         32'h0000_0000;

    // Role selection
    always_comb begin
        if (boot_sel_q && bst_q != scpm_pkg::BT_DONE) begin
            mode_d = scpm_pkg::MODE_BOOT;
        end else if (ctrl_q[scpm_pkg::CTRL_MASTER_EN]) begin
            mode_d = scpm_pkg::MODE_MASTER;
        end else begin
            mode_d = scpm_pkg::MODE_SLAVE;
        end
    end

    // Boot sequencer
    wire        half_end = (div_q == scpm_pkg::BOOT_HALF_CYC - 8'h01);
    wire        fall_now = (bst_q == scpm_pkg::BT_RUN) && half_end && bclk_q;
    wire [7:0]  bnext    = {bshift_q[6:0], din_s2_q};
    wire        byte_end = fall_now && (bbit_q[2:0] == 3'h7);
    wire        last_bit = fall_now && (bbit_q == (scpm_pkg::BOOT_BYTES << 3) - 16'h0001);

    always_comb begin
        case (bst_q)
            scpm_pkg::BT_IDLE: bst_d = (strap_done_q && boot_sel_q) ? scpm_pkg::BT_RUN : scpm_pkg::BT_IDLE;
            scpm_pkg::BT_RUN:  bst_d = last_bit ? scpm_pkg::BT_DONE : scpm_pkg::BT_RUN;
            scpm_pkg::BT_DONE: bst_d = scpm_pkg::BT_DONE;
            default:           bst_d = scpm_pkg::BT_IDLE;
        endcase
    end

    // Pin drive selection
    wire is_master = (mode_q == scpm_pkg::MODE_MASTER);
    wire is_boot   = (mode_q == scpm_pkg::MODE_BOOT);
    wire boot_run  = is_boot && (bst_q == scpm_pkg::BT_RUN);

    // Synchronisers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_s1_q  <= 3'h0;
            cfg_s2_q  <= 3'h0;
            din_s1_q  <= 1'b0;
            din_s2_q  <= 1'b0;
            sel_s1_q  <= 1'b1;
            sel_s2_q  <= 1'b1;
        end else begin
            cfg_s1_q  <= cpu_boot_config_pins;
            cfg_s2_q  <= cfg_s1_q;
            din_s1_q  <= port_data_in;
            din_s2_q  <= din_s1_q;
            sel_s1_q  <= port_select_n_i;
            sel_s2_q  <= sel_s1_q;
        end
    end

    // Word toggle from the link domain
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wtgl_s1_q <= 1'b0;
            wtgl_s2_q <= 1'b0;
            wtgl_s3_q <= 1'b0;
        end else begin
            wtgl_s1_q <= wtgl_q;
            wtgl_s2_q <= wtgl_s1_q;
            wtgl_s3_q <= wtgl_s2_q;
        end
    end

    // Boot strap capture after reset release
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strap_cnt_q  <= 2'h0;
            strap_done_q <= 1'b0;
            boot_sel_q   <= 1'b0;
        end else if (!strap_done_q) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q == scpm_pkg::STRAP_WAIT) begin
                strap_done_q <= 1'b1;
                boot_sel_q   <= (cfg_s2_q == scpm_pkg::BOOT_CFG_VALUE);
            end
        end
    end

    // Registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q    <= scpm_pkg::CTRL_RESET;
            tx_mbox_q <= 32'h0000_0000;
            rx_mbox_q <= 32'h0000_0000;
            rx_full_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= reg_wdata[3:0];
            end
            if (wr_tx) begin
                tx_mbox_q <= reg_wdata;
            end
            if (slv_word) begin
                rx_mbox_q <= lhold_q;
            end
            rx_full_q <= slv_word | (rx_full_q & ~rd_rx);
        end
    end

    // Read data, standing one cycle after the strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= reg_rd ? rsel_w : 32'h0000_0000;
        end
    end

    // Boot clock, bit counter and byte capture
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bst_q        <= scpm_pkg::BT_IDLE;
            div_q        <= 8'h00;
            bclk_q       <= 1'b0;
            bbit_q       <= 16'h0000;
            bshift_q     <= 8'h00;
            boot_byte_q  <= 8'h00;
            boot_valid_q <= 1'b0;
        end else begin
            bst_q        <= bst_d;
            boot_valid_q <= byte_end;
            if (bst_q == scpm_pkg::BT_RUN) begin
                div_q <= half_end ? 8'h00 : div_q + 8'h01;
                if (half_end) begin
                    bclk_q <= ~bclk_q;
                end
            end else begin
                div_q  <= 8'h00;
                bclk_q <= 1'b0;
            end
            if (fall_now) begin
                bshift_q <= bnext;
                bbit_q   <= bbit_q + 16'h0001;
            end
            if (byte_end) begin
                boot_byte_q <= bnext;
            end
        end
    end

    // Boot completion flag
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            boot_done_q <= 1'b0;
        end else begin
            boot_done_q <= (bst_d == scpm_pkg::BT_DONE);
        end
    end

    // Next pin levels
    wire slave_en_d = strap_done_q && (mode_d == scpm_pkg::MODE_SLAVE);
    wire clk_o_d    = is_master ? ctrl_q[scpm_pkg::CTRL_M_CLK] : bclk_q;
    wire clk_oe_d   = is_master | boot_run;
    wire mdo_d      = ctrl_q[scpm_pkg::CTRL_M_DOUT];
    wire mdo_oe_d   = is_master;
    wire sel_o_d    = is_master ? ctrl_q[scpm_pkg::CTRL_M_SEL_N] : 1'b0;
    wire sel_oe_d   = is_master | boot_run;

    // Role register and pin drivers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_q     <= scpm_pkg::MODE_SLAVE;
            slave_en_q <= 1'b0;
            clk_o_q    <= 1'b0;
            clk_oe_q   <= 1'b0;
            mdo_q      <= 1'b0;
            mdo_oe_q   <= 1'b0;
            sel_o_q    <= 1'b1;
            sel_oe_q   <= 1'b0;
        end else begin
            mode_q     <= mode_d;
            slave_en_q <= slave_en_d;
            clk_o_q    <= clk_o_d;
            clk_oe_q   <= clk_oe_d;
            mdo_q      <= mdo_d;
            mdo_oe_q   <= mdo_oe_d;
            sel_o_q    <= sel_o_d;
            sel_oe_q   <= sel_oe_d;
        end
    end

    // Link side: frame logic held in reset while deselected or not in slave role
    wire link_rst_n = nrst & ~port_select_n_i & slave_en_q;

    always_ff @(posedge port_clk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            lcnt_q <= 6'h00;
            lcmd_q <= 8'h00;
            lsh_q  <= 32'h0000_0000;
        end else begin
            if (lcnt_q != scpm_pkg::FRM_END) begin
                lcnt_q <= lcnt_q + 6'h01;
            end
            if (lcnt_q < scpm_pkg::FRM_CMD_BITS) begin
                lcmd_q <= {lcmd_q[6:0], port_data_in};
            end else begin
                lsh_q <= {lsh_q[30:0], port_data_in};
            end
        end
    end

    // Link side: completed write word, kept across frames
    wire lwr_fire = (lcnt_q == scpm_pkg::FRM_LAST_BIT) && lcmd_q[scpm_pkg::CMD_WRITE]
                    && (lcmd_q[6:0] == scpm_pkg::IDX_MBOX);

    always_ff @(posedge port_clk_i or negedge nrst) begin
        if (!nrst) begin
            lhold_q <= 32'h0000_0000;
            wtgl_q  <= 1'b0;
        end else if (lwr_fire) begin
            lhold_q <= {lsh_q[30:0], port_data_in};
            wtgl_q  <= ~wtgl_q;
        end
    end

    // Link side: response bits launched on the falling edge
    wire [5:0] tx_idx = scpm_pkg::FRM_LAST_BIT - lcnt_q;
    wire       tx_on  = (lcnt_q >= scpm_pkg::FRM_CMD_BITS) && (lcnt_q < scpm_pkg::FRM_END)
                        && !lcmd_q[scpm_pkg::CMD_WRITE] && (lcmd_q[6:0] == scpm_pkg::IDX_MBOX);

    always_ff @(negedge port_clk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            so_q  <= 1'b0;
            soe_q <= 1'b0;
        end else begin
            so_q  <= tx_on ? tx_mbox_q[tx_idx[4:0]] : 1'b0;
            soe_q <= 1'b1;
        end
    end

    // Outputs
    assign reg_rdata        = rdata_q;
    assign boot_byte        = boot_byte_q;
    assign boot_byte_valid  = boot_valid_q;
    assign boot_done        = boot_done_q;
    assign port_clk_o       = clk_o_q;
    assign port_clk_oe      = clk_oe_q;
    assign port_data_out    = is_master ? mdo_q : so_q;
    assign port_data_out_oe = is_master ? mdo_oe_q : (soe_q & slave_en_q);
    assign port_select_n_o  = sel_o_q;
    assign port_select_n_oe = sel_oe_q;

endmodule

/* verif/scpm_chk.sv */
module scpm_chk (
    // System
    input wire logic        clk,
    input wire logic        nrst,
    // Register port
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // Boot stream
    input wire logic        boot_byte_valid,
    input wire logic        boot_done,
    // Pins
    input wire logic        port_clk_oe,
    input wire logic        port_clk_o,
    input wire logic        port_data_out,
    input wire logic        port_data_out_oe,
    input wire logic        port_select_n_i,
    input wire logic        port_select_n_o,
    input wire logic        port_select_n_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire logic ctrl_wr = reg_wr && reg_addr == scpm_pkg::OFF_CTRL;
    // Control write while already driving, with no write right after
    sequence s_set;
        ctrl_wr && reg_wdata[0] && port_clk_oe ##1 !ctrl_wr;
    endsequence
    // Slave side idle and deselected for four cycles
    sequence s_quiet;
        (!port_clk_oe && port_select_n_i && !ctrl_wr) [*4];
    endsequence
    a_oe_pair: assert property (port_clk_oe == port_select_n_oe)
        else $error("clock and select enables differ");
    a_dout_hiz: assert property (s_quiet |-> !port_data_out_oe)
        else $error("data out driven while deselected");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside read cycle");
    a_master_clk: assert property (s_set |=> port_clk_o == $past(reg_wdata[1], 2))
        else $error("clock pin does not follow its bit");
    a_master_pins: assert property (s_set |=> port_data_out_oe &&
        {port_select_n_o, port_data_out} == $past(reg_wdata[3:2], 2))
        else $error("select or data pin does not follow its bit");
    a_boot_sel: assert property ($rose(boot_byte_valid) && !boot_done |->
        $past(port_select_n_oe) && !$past(port_select_n_o) && $past(port_clk_oe))
        else $error("boot byte without select and clock driven");
    a_boot_release: assert property (boot_done [*3] |-> !port_select_n_oe && !port_clk_oe)
        else $error("pins still driven after boot");
    a_done_sticky: assert property (boot_done |=> boot_done)
        else $error("boot done dropped");
    a_valid_pulse: assert property (boot_byte_valid |=> !boot_byte_valid [*8])
        else $error("boot byte pulses too close");
endmodule

bind scpm_top scpm_chk scpm_chk_i (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .boot_byte_valid(boot_byte_valid),
    .boot_done(boot_done), .port_clk_oe(port_clk_oe), .port_clk_o(port_clk_o), .port_data_out(port_data_out),
    .port_data_out_oe(port_data_out_oe), .port_select_n_i(port_select_n_i), .port_select_n_o(port_select_n_o),
    .port_select_n_oe(port_select_n_oe));

/* verif/scpm_mem.sv */
module scpm_mem (
    // Pins from the block
    input wire logic clk_pin,
    input wire logic clk_oe,
    input wire logic sel_n,
    input wire logic sel_oe,
    // Data back to the block
    output logic     dout
);
    timeunit 1ns;
    timeprecision 1ps;
    int         n = 0;
    logic       drive;
    logic       bit_v;
    logic       last_q = 1'b0;
    logic [7:0] cur;
    assign drive = sel_oe && !sel_n;
    assign cur = 8'h5A + 8'(n / 8) * 8'h27;
    assign bit_v = cur[7 - n % 8];
    assign dout = drive ? bit_v : ~last_q;
    always @(posedge drive) n = 0;
    always @(negedge clk_pin) if (drive && clk_oe) n = n + 1;
    always @(bit_v or drive) if (drive) last_q = bit_v;
endmodule

/* verif/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata, rv;
    logic [2:0]  cfg = 3'h0;
    logic [7:0]  boot_byte;
    logic        boot_byte_valid, boot_done, port_clk_o, port_clk_oe, mem_do;
    logic        port_data_out, port_data_out_oe, port_select_n_o, port_select_n_oe;
    logic        tb_clk = 1'b0, tb_din = 1'b0, tb_sel = 1'b1, use_mem = 1'b0;
    wire logic   port_data_in = use_mem ? mem_do : tb_din;
    wire logic   port_clk_i = port_clk_oe ? port_clk_o : tb_clk;
    wire logic   port_select_n_i = port_select_n_oe ? port_select_n_o : tb_sel;
    int          num_errors = 0;
    int          cmp_count = 0;
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
    scpm_top scpm_top_i (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_boot_config_pins(cfg), .boot_byte(boot_byte),
        .boot_byte_valid(boot_byte_valid), .boot_done(boot_done), .port_clk_i(port_clk_i),
        .port_clk_o(port_clk_o), .port_clk_oe(port_clk_oe), .port_data_in(port_data_in),
        .port_data_out(port_data_out), .port_data_out_oe(port_data_out_oe), .port_select_n_i(port_select_n_i),
        .port_select_n_o(port_select_n_o), .port_select_n_oe(port_select_n_oe));
    scpm_mem scpm_mem_i (.clk_pin(port_clk_o), .clk_oe(port_clk_oe), .sel_n(port_select_n_o),
        .sel_oe(port_select_n_oe), .dout(mem_do));
    always #10 clk = ~clk;
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask
    task automatic do_reset(input logic [2:0] strap);
        @(posedge clk);
        nrst <= 1'b0;
        cfg <= strap;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    // One slave frame at the link rate, clock still outside it
    task automatic frame(input logic [7:0] cmd, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        #3 tb_sel = 1'b0;
        #200;
        for (int i = 0; i < 40; i++) begin
            tb_din = i < 8 ? cmd[7 - i] : d[39 - i];
            #62.5 tb_clk = 1'b1;
            q = {q[30:0], port_data_out};
            if (i == 20) `CHK("link_oe", 2'b01, {port_clk_oe, port_data_out_oe})
            #62.5 tb_clk = 1'b0;
        end
        tb_din = ~tb_din;
        #200 tb_sel = 1'b1;
        repeat (6) @(posedge clk);
    endtask
    task automatic t_regs();
        do_reset(3'h0);
        rd(scpm_pkg::OFF_CTRL, rv);
        `CHK("ctrl", 32'h0000_0008, rv)
        rd(scpm_pkg::OFF_STATUS, rv);
        `CHK("role", 3'b001, rv[2:0])
        rd(8'h14, rv);
        `CHK("unmapped", 32'h0000_0000, rv)
        wr(scpm_pkg::OFF_TX_MBOX, 32'hC0DE_F00D);
        rd(scpm_pkg::OFF_TX_MBOX, rv);
        `CHK("tx_mbox", 32'hC0DE_F00D, rv)
    endtask
    task automatic t_slave();
        logic [31:0] q;
        frame(8'h80, 32'h1234_5678, q);
        `CHK("dout_oe", 1'b0, port_data_out_oe)
        rd(scpm_pkg::OFF_STATUS, rv);
        `CHK("rx_full", 1'b1, rv[6])
        frame(8'h81, 32'hDEAD_BEEF, q);
        rd(scpm_pkg::OFF_RX_MBOX, rv);
        `CHK("rx_mbox", 32'h1234_5678, rv)
        rd(scpm_pkg::OFF_STATUS, rv);
        `CHK("rx_clear", 1'b0, rv[6])
        frame(8'h00, 32'h0000_0000, q);
        `CHK("slave_read", 32'hC0DE_F00D, q)
    endtask
    task automatic t_master();
        logic [5:0] pins;
        do_reset(3'h0);
        wr(scpm_pkg::OFF_CTRL, 32'h0000_0001);
        for (int v = 0; v < 8; v++) begin
            tb_din <= v[0];
            wr(scpm_pkg::OFF_CTRL, {28'h0, v[2:0], 1'b1});
            repeat (3) @(posedge clk);
            pins = {port_clk_oe, port_data_out_oe, port_select_n_oe, port_select_n_o, port_data_out, port_clk_o};
            `CHK("pins", {3'b111, v[2:0]}, pins)
            rd(scpm_pkg::OFF_STATUS, rv);
            `CHK("din", {v[0], 3'b010}, rv[3:0])
        end
    endtask
    task automatic t_boot();
        int k;
        logic [3:0] pins;
        use_mem = 1'b1;
        do_reset(3'h1);
        for (int b = 0; b < 16; b++) begin
            k = 0;
            do begin
                @(negedge clk);
                k++;
            end while (boot_byte_valid !== 1'b1 && k < 200);
            `CHK("boot_wait", 1'b1, k < 200)
            `CHK("boot_byte", 8'h5A + 8'(b) * 8'h27, boot_byte)
            pins = {port_select_n_oe, port_select_n_o, port_data_out_oe, port_clk_oe};
            if (b == 0) `CHK("boot_pins", 4'b1001, pins)
        end
        k = 0;
        while (boot_done !== 1'b1 && k < 200) begin
            @(negedge clk);
            k++;
        end
        `CHK("done_wait", 1'b1, k < 200)
        repeat (4) @(negedge clk);
        `CHK("released", 3'b000, {port_select_n_oe, port_clk_oe, port_data_out_oe})
        rd(scpm_pkg::OFF_STATUS, rv);
        `CHK("boot_status", 4'b1001, {rv[4], rv[2:0]})
        rd(scpm_pkg::OFF_BOOTCNT, rv);
        `CHK("boot_bits", 16'h0080, rv[15:0])
    endtask
    task automatic wrap_up();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        t_regs();
        t_slave();
        t_master();
        t_boot();
        wrap_up();
    end
    initial begin
        #200_000;
        num_errors++;
        wrap_up();
    end
endmodule
